// ---- dv/testbench.sv ----
// self-checking bench of the tug-3 adaptation sink
`timescale 1ns/1ns
`default_nettype none
`include "tmas_map.svh"
module testbench;
  localparam int LOMC = 2000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, path_data, tug3_data, adapted_data_out, base;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic path_clk, path_fs, incoming_trail_fail, tug3_stb, tug3_fs, tug3_mfs, run, stuck, ais;
  logic tu3_server_fail_out, tug2_server_fail_out, tu3_trail_fail_action, tug2_trail_fail_action;
  logic vc3_stb, vc3_fs, vc3_server_fail, dchk;
  logic [2:0] label;
  logic [9:0] ptr;
  logic [15:0] lfsr;
  int failures, cmp_count, fs_seen, mfs_seen;
  tmas_sink #(.LOM_CYCLES(LOMC), .TIMESLOT(1'b0)) i_tmas_sink (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .path_clk, .path_data, .path_fs,
    .incoming_trail_fail, .tug3_data, .tug3_stb, .tug3_fs, .tug3_mfs, .tu3_server_fail_out,
    .tug2_server_fail_out, .tu3_trail_fail_action, .tug2_trail_fail_action, .adapted_data_out,
    .vc3_stb, .vc3_fs, .vc3_server_fail);
  tmas_path_model i_tmas_path_model (.aclk, .aresetn, .run, .label, .mf_stuck(stuck), .ais,
    .ptr, .base, .path_clk, .path_data, .path_fs);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction : nxt
  // payload byte n of slot a carries base xor n, so the byte at the pointer is known
  function automatic logic [7:0] pay_byte(input logic [7:0] bs, input logic [9:0] p);
    return bs ^ p[7:0];
  endfunction : pay_byte
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) failures++;
    if (n == 40) conclude();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    if (n == 40) failures++;
    if (n == 40) conclude();
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rdr
  // status is polled; blind waits are LOMC - 300 cycles before the early loss check and 40 before the output check: the design's latencies stay its own
  task automatic poll(input logic [31:0] m, input logic [31:0] v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      rdr(`TMAS_STAT_ADDR, `TMAS_RESP_OK);
      if ((rd & m) === v) break;
    end
    chk(rd & m, v);
  endtask : poll
  always @(posedge aclk) begin
    if (tug3_mfs === 1'b1) mfs_seen++;
    if (dchk && vc3_fs === 1'b1 && vc3_server_fail === 1'b0) begin
      fs_seen++;
      chk({24'h0, adapted_data_out}, {24'h0, pay_byte(base, ptr)});
    end
  end
  initial begin
    logic [2:0] l;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {run, stuck, ais, incoming_trail_fail, dchk} = 5'h00;
    label = `TMAS_EXP_LABEL;
    ptr = 10'h003;
    lfsr = 16'hFDDE;
    base = 8'hDE;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, tu3_server_fail_out, tug2_server_fail_out}, 32'h3);
    chk({24'h0, adapted_data_out}, 32'hFF);
    rdr(`TMAS_STAT_ADDR, `TMAS_RESP_OK);
    chk(rd, 32'h880);
    rdr(8'h10, `TMAS_RESP_ERR);
    wr(8'h10, 32'h7, `TMAS_RESP_ERR);
    wr(`TMAS_STAT_ADDR, 32'hFFF, `TMAS_RESP_OK);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wr(`TMAS_CTRL_ADDR, {29'h0, lfsr[2:0]}, `TMAS_RESP_OK);
      rdr(`TMAS_CTRL_ADDR, `TMAS_RESP_OK);
      chk(rd, {29'h0, lfsr[2:0]});
    end
    $display("test registers done");
    base = lfsr[15:8];
    wr(`TMAS_CTRL_ADDR, 32'h3, `TMAS_RESP_OK);
    run <= 1'b1;
    poll(32'h1A0, 32'h100, 400);
    poll(32'h80, 32'h0, 400);
    chk({30'h0, tu3_server_fail_out, tug2_server_fail_out}, 32'h0);
    dchk = 1'b1;
    repeat (400) @(posedge aclk);
    dchk = 1'b0;
    chk({31'h0, fs_seen > 0}, 32'h1);
    chk({31'h0, mfs_seen > 0}, 32'h1);
    $display("test alignment done");
    stuck <= 1'b1;
    poll(32'h100, 32'h0, 60);
    repeat (LOMC - 300) @(posedge aclk);
    poll(32'h20, 32'h0, 1);
    poll(32'h22, 32'h22, 200);
    chk({30'h0, tu3_server_fail_out, tug2_server_fail_out}, 32'h1);
    incoming_trail_fail <= 1'b1;
    poll(32'h2, 32'h0, 20);
    incoming_trail_fail <= 1'b0;
    stuck <= 1'b0;
    poll(32'h122, 32'h100, 400);
    $display("test multiframe loss done");
    lfsr = nxt(lfsr);
    l = (lfsr[2:0] == `TMAS_EXP_LABEL) ? 3'h5 : lfsr[2:0];
    label <= l;
    poll(32'hE11, {20'h0, l, 9'h011}, 400);
    chk({30'h0, tu3_server_fail_out, tug2_server_fail_out}, 32'h3);
    incoming_trail_fail <= 1'b1;
    poll(32'h1, 32'h0, 20);
    incoming_trail_fail <= 1'b0;
    label <= `TMAS_EXP_LABEL;
    poll(32'hE11, 32'h800, 400);
    $display("test label done");
    ais <= 1'b1;
    poll(32'h48, 32'h40, 400);
    chk({31'h0, vc3_server_fail}, 32'h1);
    wr(`TMAS_CTRL_ADDR, 32'h7, `TMAS_RESP_OK);
    poll(32'h8, 32'h8, 10);
    // the tu-3 trail fail follows the label stage only; switching it off raises it
    wr(`TMAS_CTRL_ADDR, 32'h6, `TMAS_RESP_OK);
    poll(32'h8, 32'h0, 20);
    wr(`TMAS_CTRL_ADDR, 32'h7, `TMAS_RESP_OK);
    ais <= 1'b0;
    ptr <= 10'h3F0;
    poll(32'hC4, 32'h84, 500);
    $display("test pointer done");
    wr(`TMAS_CTRL_ADDR, 32'h0, `TMAS_RESP_OK);
    poll(32'hF, 32'h0, 10);
    repeat (40) @(posedge aclk);
    chk({22'h0, adapted_data_out, tu3_server_fail_out, tug2_server_fail_out}, 32'h3FF);
    $display("test deactivation done");
    conclude();
  end
endmodule : testbench
`default_nettype wire

// ---- dv/tmas_path_model.sv ----
// upstream path model: byte clock, label byte and two interleaved tu-3 slots
`timescale 1ns/1ns
`default_nettype none
module tmas_path_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame content
  input wire logic run,
  input wire logic [2:0] label,
  input wire logic mf_stuck,
  input wire logic ais,
  input wire logic [9:0] ptr,
  input wire logic [7:0] base,
  // path pins
  output logic path_clk,
  output logic [7:0] path_data,
  output logic path_fs
);
  localparam int LEN = 21;
  logic [2:0] ph;
  logic [4:0] idx;
  logic [1:0] mf;
  logic [3:0] s;
  logic [7:0] b;
  logic [2:0] lab_q;
  logic ais_q;
  logic [9:0] ptr_q;
  // both slots carry the same pointer, slot b inverted so a wrong slot shows
  assign s = 4'((idx - 5'h01) >> 1);
  assign b = (s == 4'h0) ? (ais_q ? 8'hFF : {6'h18, ptr_q[9:8]}) :
             (s == 4'h1) ? (ais_q ? 8'hFF : ptr_q[7:0]) : base ^ 8'(s - 4'h2);
  // while run is low the data lines toggle so no stale byte can be mistaken
  assign path_data = !run ? {8{ph[0]}} : (idx == 5'h00) ? {2'h0, lab_q, mf, 1'b0} :
                     idx[0] ? b : ~b;
  assign path_fs = run && (idx == 5'h00);
  // content is latched at the byte boundary, so a byte never changes under the clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 3'h0;
      mf <= 2'h0;
      path_clk <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      path_clk <= run && ph[2];
    end
    if (!aresetn || !run || ph == 3'h0) begin
      lab_q <= label;
      ais_q <= ais;
      ptr_q <= ptr;
    end
    if (!aresetn || !run) begin
      idx <= 5'h00;
    end else if (ph == 3'h0) begin
      idx <= (idx == 5'(LEN - 1)) ? 5'h00 : idx + 5'h01;
      if (idx == 5'(LEN - 1) && !mf_stuck) begin
        mf <= mf + 2'h1;
      end
    end
  end
endmodule : tmas_path_model
`default_nettype wire

// ---- dv/tmas_sink_chk.sv ----
// port-level assertions of the tug-3 adaptation sink
`timescale 1ns/1ns
`default_nettype none
module tmas_sink_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // path and tug-3 side
  input wire logic [7:0] path_data,
  input wire logic path_fs,
  input wire logic [7:0] tug3_data,
  input wire logic tug3_stb,
  input wire logic tug3_fs,
  input wire logic tug3_mfs,
  input wire logic tu3_server_fail_out,
  input wire logic tug2_server_fail_out,
  input wire logic tu3_trail_fail_action,
  input wire logic tug2_trail_fail_action,
  // vc-3 side
  input wire logic [7:0] adapted_data_out,
  input wire logic vc3_stb,
  input wire logic vc3_fs,
  input wire logic vc3_server_fail
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_fail_a: assert property ($rose(aresetn) |-> tu3_server_fail_out && tug2_server_fail_out)
    else $error("server fails not set after reset");
  tf_tu3_a: assert property (tu3_trail_fail_action == tu3_server_fail_out)
    else $error("tu3 trail fail differs from server fail");
  tf_tug2_a: assert property (tug2_trail_fail_action == tug2_server_fail_out)
    else $error("tug2 trail fail differs from server fail");
  fail_order_a: assert property (tu3_server_fail_out |-> tug2_server_fail_out)
    else $error("tu3 fail without tug2 fail");
  // the path byte is stable for several cycles around the take, so depth 2 is safe
  pass_byte_a: assert property (tug3_stb |-> {tug3_fs, tug3_data} == $past({path_fs, path_data}, 2))
    else $error("tug3 byte not passed unchanged");
  stb_pulse_a: assert property (tug3_stb |=> !tug3_stb [*5])
    else $error("tug3 strobe too long");
  mf_code_a: assert property (tug3_mfs |-> tug3_fs && tug3_data[2:1] == 2'h1)
    else $error("multiframe start on wrong byte");
  vc3_fs_a: assert property (vc3_fs |-> vc3_stb)
    else $error("vc3 frame start without strobe");
  ais_fill_a: assert property (vc3_stb && vc3_server_fail && $past(vc3_server_fail, 8)
    |-> adapted_data_out == 8'hFF)
    else $error("no all-ones under vc3 server fail");
endmodule : tmas_sink_chk
bind tmas_sink tmas_sink_chk i_tmas_sink_chk (.aclk, .aresetn, .path_data, .path_fs, .tug3_data,
  .tug3_stb, .tug3_fs, .tug3_mfs, .tu3_server_fail_out, .tug2_server_fail_out,
  .tu3_trail_fail_action, .tug2_trail_fail_action, .adapted_data_out, .vc3_stb, .vc3_fs,
  .vc3_server_fail);
`default_nettype wire

// ---- verilog/tmas_map.svh ----
// address map, field positions, reset values and timing figures of the sink
`ifndef TMAS_MAP_SVH
`define TMAS_MAP_SVH
`define TMAS_CTRL_ADDR 8'h00
`define TMAS_STAT_ADDR 8'h04
`define TMAS_CTRL_RST 3'h0
`define TMAS_CTL_LBL_ACT 0
`define TMAS_CTL_VC3_ACT 1
`define TMAS_CTL_AIS_REP 2
`define TMAS_RESP_OK 2'h0
`define TMAS_RESP_ERR 2'h2
`define TMAS_LBL_HI 5
`define TMAS_LBL_LO 3
`define TMAS_MF_HI 2
`define TMAS_MF_LO 1
`define TMAS_EXP_LABEL 3'h4
`define TMAS_LBL_ACCEPT 3'h5
`define TMAS_MF_GOOD 3'h4
`define TMAS_MF_FIRST 2'h1
`define TMAS_MF_STEP 2'h1
`define TMAS_LABEL_POS 12'h000
`define TMAS_POH_BYTES 12'h001
`define TMAS_PTR1_IDX 11'h000
`define TMAS_PTR2_IDX 11'h001
`define TMAS_LOM_TIME_US 3000
`define TMAS_CLK_MHZ 100
`define TMAS_ALL_ONES 8'hFF
`define TMAS_NDF_NORMAL 4'h6
`define TMAS_NDF_ENABLED 4'h9
`define TMAS_PTR_MAX 10'h2FC
`define TMAS_AIS_FRAMES 2'h3
`define TMAS_NORM_FRAMES 2'h3
`define TMAS_LOP_FRAMES 4'h8
`endif

// ---- verilog/tmas_pkg.sv ----
// types shared by the sink modules
package tmas_pkg;
  typedef enum logic {out_of_multiframe_state, in_multiframe_state} tmas_mf_state_type;
  typedef enum logic [1:0] {tmas_pi_norm, tmas_pi_ais, tmas_pi_lop} tmas_pi_state_type;
endpackage : tmas_pkg

// ---- verilog/tmas_ptr_if.sv ----
// link between the adaptation stage and the vc-3 pointer sink
`timescale 1ns/1ns
`default_nettype none
interface tmas_ptr_if;
  logic byte_stb;
  logic [7:0] data;
  logic frame_start;
  logic is_ptr1;
  logic is_ptr2;
  logic is_pay;
  logic tsf;
  logic activate;
  logic ais_opt;
  logic [7:0] out_data;
  logic out_stb;
  logic out_fs;
  logic ssf;
  logic ais_def;
  logic lop_def;
  logic ais_cause;
  logic lop_cause;
  modport feed (output byte_stb, data, frame_start, is_ptr1, is_ptr2, is_pay, tsf,
                activate, ais_opt,
                input out_data, out_stb, out_fs, ssf, ais_def, lop_def, ais_cause,
                lop_cause);
  modport sink (input byte_stb, data, frame_start, is_ptr1, is_ptr2, is_pay, tsf,
                activate, ais_opt,
                output out_data, out_stb, out_fs, ssf, ais_def, lop_def, ais_cause,
                lop_cause);
endinterface : tmas_ptr_if
`default_nettype wire

// ---- verilog/tmas_ptr_sink.sv ----
// vc-3 sink: tu-3 pointer interpretation and all-ones insertion
`timescale 1ns/1ns
`default_nettype none
`include "tmas_map.svh"
module tmas_ptr_sink
  import tmas_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // stream from the adaptation stage
  tmas_ptr_if.sink p
);
  tmas_pi_state_type state;
  logic [7:0] h1;
  logic [9:0] ptr_act;
  logic [9:0] ptr_last;
  logic [1:0] ais_cnt;
  logic [1:0] norm_cnt;
  logic [3:0] inv_cnt;
  logic [11:0] pay_cnt;
  wire [9:0] ptr_val = {h1[1:0], p.data};
  wire all_ones = (h1 == `TMAS_ALL_ONES) && (p.data == `TMAS_ALL_ONES);
  wire ptr_ok = ptr_val <= `TMAS_PTR_MAX;
  wire ndf_norm = (h1[7:4] == `TMAS_NDF_NORMAL) && ptr_ok;
  wire ndf_new = (h1[7:4] == `TMAS_NDF_ENABLED) && ptr_ok;
  wire ptr_eval = p.byte_stb && p.is_ptr2;
  wire ais_hit = all_ones && (ais_cnt == `TMAS_AIS_FRAMES - 2'h1);
  wire norm_hit = ndf_norm && (ptr_val == ptr_last)
                  && (norm_cnt == `TMAS_NORM_FRAMES - 2'h1);
  wire inv_hit = !all_ones && !ndf_norm && !ndf_new
                 && (inv_cnt == `TMAS_LOP_FRAMES - 4'h1);
  wire ais_def = state == tmas_pi_ais;
  wire lop_def = state == tmas_pi_lop;
  // all-ones is applied on the next byte, well inside the 250 us limit
  wire all_ones_act = ais_def || lop_def || p.tsf || !p.activate;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h1 <= 8'h00;
    end else if (p.byte_stb && p.is_ptr1) begin
      h1 <= p.data;
    end
  end

  // pointer interpreter: norm / ais / lop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tmas_pi_lop;
      ptr_act <= 10'h000;
      ptr_last <= 10'h000;
      ais_cnt <= 2'h0;
      norm_cnt <= 2'h0;
      inv_cnt <= 4'h0;
    end else if (ptr_eval) begin
      ptr_last <= ptr_val;
      ais_cnt <= all_ones ? ais_cnt + 2'h1 : 2'h0;
      norm_cnt <= (ndf_norm && ptr_val == ptr_last) ? norm_cnt + 2'h1 : 2'h0;
      inv_cnt <= (!all_ones && !ndf_norm && !ndf_new) ? inv_cnt + 4'h1 : 4'h0;
      case (state)
        tmas_pi_norm: begin
          if (ais_hit) begin
            state <= tmas_pi_ais;
          end else if (inv_hit) begin
            state <= tmas_pi_lop;
          end else if (ndf_new || norm_hit) begin
            ptr_act <= ptr_val;
          end
        end
        tmas_pi_ais, tmas_pi_lop: begin
          if (norm_hit) begin
            state <= tmas_pi_norm;
            ptr_act <= ptr_val;
          end else if (ais_hit) begin
            state <= tmas_pi_ais;
          end else if (inv_hit) begin
            state <= tmas_pi_lop;
          end
        end
        default: state <= tmas_pi_lop;
      endcase
    end
  end

  // payload byte count locates the vc-3 start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pay_cnt <= 12'h000;
    end else if (p.byte_stb && p.frame_start) begin
      pay_cnt <= 12'h000;
    end else if (p.byte_stb && p.is_pay) begin
      pay_cnt <= pay_cnt + 12'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p.out_data <= `TMAS_ALL_ONES;
      p.out_stb <= 1'b0;
      p.out_fs <= 1'b0;
      p.ssf <= 1'b1;
      p.ais_def <= 1'b0;
      p.lop_def <= 1'b0;
      p.ais_cause <= 1'b0;
      p.lop_cause <= 1'b0;
    end else begin
      p.out_stb <= p.byte_stb && p.is_pay;
      p.out_fs <= p.byte_stb && p.is_pay && (pay_cnt == {2'h0, ptr_act});
      if (p.byte_stb && p.is_pay) begin
        p.out_data <= all_ones_act ? `TMAS_ALL_ONES : p.data;
      end
      p.ssf <= ais_def || lop_def || p.tsf;
      p.ais_def <= ais_def;
      p.lop_def <= lop_def;
      p.lop_cause <= p.activate && lop_def && !p.tsf;
      p.ais_cause <= p.activate && ais_def && !p.tsf && p.ais_opt;
    end
  end
endmodule : tmas_ptr_sink
`default_nettype wire

// ---- verilog/tmas_sink.sv ----
// path label / multiframe adaptation, trail termination and vc-3 sink top
`timescale 1ns/1ns
`default_nettype none
`include "tmas_map.svh"
module tmas_sink
  import tmas_pkg::*;
#(
  parameter int unsigned LOM_CYCLES = `TMAS_LOM_TIME_US * `TMAS_CLK_MHZ,
  parameter bit TIMESLOT = 1'b0
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // incoming path, on the path clock
  input wire logic path_clk,
  input wire logic [7:0] path_data,
  input wire logic path_fs,
  input wire logic incoming_trail_fail,
  // tug-3 access point after the trail stage
  output logic [7:0] tug3_data,
  output logic tug3_stb,
  output logic tug3_fs,
  output logic tug3_mfs,
  output logic tu3_server_fail_out,
  output logic tug2_server_fail_out,
  output logic tu3_trail_fail_action,
  output logic tug2_trail_fail_action,
  // vc-3 output
  output logic [7:0] adapted_data_out,
  output logic vc3_stb,
  output logic vc3_fs,
  output logic vc3_server_fail
);
  tmas_ptr_if pif ();
  tmas_mf_state_type mf_state;
  logic [2:0] ctrl;
  logic [2:0] ck_s;
  logic [7:0] d1, d2, d3;
  logic [2:0] fs_s;
  logic [2:0] tf_s;
  logic trail_fail_in;
  logic [11:0] pos;
  logic [2:0] lbl_last;
  logic [2:0] lbl_cnt;
  logic [2:0] label_accepted;
  logic [1:0] mf_prev;
  logic [2:0] mf_good;
  logic [31:0] lom_timer;
  logic multiframe_loss_defect;
  logic label_mismatch_cause;
  logic multiframe_loss_cause;
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // path clock edge found from the synchronised copy; data are stable by then
  wire byte_stb = ck_s[1] && !ck_s[2];
  wire fs_now = fs_s[2];
  wire [11:0] cur_pos = fs_now ? 12'h000 : pos + 12'h001;
  wire is_label = byte_stb && (cur_pos == `TMAS_LABEL_POS);
  wire [11:0] pay_pos = cur_pos - `TMAS_POH_BYTES;
  wire in_pay = cur_pos >= `TMAS_POH_BYTES;
  // timeslots a and b are byte interleaved; only one serves this sink
  wire my_slot = in_pay && (pay_pos[0] == TIMESLOT);
  wire [10:0] slot_idx = pay_pos[11:1];
  wire [2:0] lbl_now = d3[`TMAS_LBL_HI:`TMAS_LBL_LO];
  wire [1:0] mf_code = d3[`TMAS_MF_HI:`TMAS_MF_LO];
  wire mf_ok = mf_code == mf_prev + `TMAS_MF_STEP;
  wire label_mismatch_defect = label_accepted != `TMAS_EXP_LABEL;
  wire lbl_act = ctrl[`TMAS_CTL_LBL_ACT];
  wire tu3_server_fail_action = !lbl_act || label_mismatch_defect;
  wire tug2_server_fail_action = !lbl_act || label_mismatch_defect
                                 || multiframe_loss_defect;
  wire in_mf = mf_state == in_multiframe_state;

  // three-stage capture of everything that arrives on the path clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s <= 3'h0;
      fs_s <= 3'h0;
      tf_s <= 3'h0;
      d1 <= 8'h00;
      d2 <= 8'h00;
      d3 <= 8'h00;
    end else begin
      ck_s <= {ck_s[1:0], path_clk};
      fs_s <= {fs_s[1:0], path_fs};
      tf_s <= {tf_s[1:0], incoming_trail_fail};
      d1 <= path_data;
      d2 <= d1;
      d3 <= d2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trail_fail_in <= 1'b0;
      pos <= 12'h000;
    end else begin
      if (tf_s[1] == tf_s[2]) begin
        trail_fail_in <= tf_s[2];
      end
      if (byte_stb) begin
        pos <= cur_pos;
      end
    end
  end

  // label acceptance: a new code counts after five equal frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lbl_last <= `TMAS_EXP_LABEL;
      lbl_cnt <= 3'h0;
      label_accepted <= `TMAS_EXP_LABEL;
    end else if (is_label) begin
      lbl_last <= lbl_now;
      if (lbl_now != lbl_last) begin
        lbl_cnt <= 3'h1;
      end else if (lbl_cnt != `TMAS_LBL_ACCEPT) begin
        lbl_cnt <= lbl_cnt + 3'h1;
      end
      if (lbl_now == lbl_last && lbl_cnt == `TMAS_LBL_ACCEPT - 3'h1) begin
        label_accepted <= lbl_now;
      end
    end
  end

  // multiframe aligner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mf_state <= out_of_multiframe_state;
      mf_prev <= 2'h0;
      mf_good <= 3'h0;
    end else if (is_label) begin
      mf_prev <= mf_code;
      case (mf_state)
        out_of_multiframe_state: begin
          mf_good <= mf_ok ? mf_good + 3'h1 : 3'h0;
          if (mf_ok && mf_good == `TMAS_MF_GOOD - 3'h1) begin
            mf_state <= in_multiframe_state;
          end
        end
        in_multiframe_state: begin
          mf_good <= 3'h0;
          if (!mf_ok) begin
            mf_state <= out_of_multiframe_state;
          end
        end
        default: mf_state <= out_of_multiframe_state;
      endcase
    end
  end

  // loss-of-multiframe timer runs on aclk, so its length does not hang on the path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lom_timer <= 32'h0;
      multiframe_loss_defect <= 1'b0;
    end else if (in_mf) begin
      lom_timer <= 32'h0;
      multiframe_loss_defect <= 1'b0;
    end else if (lom_timer >= LOM_CYCLES - 32'h1) begin
      multiframe_loss_defect <= 1'b1;
    end else begin
      lom_timer <= lom_timer + 32'h1;
    end
  end

  // fault causes and the trail stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      label_mismatch_cause <= 1'b0;
      multiframe_loss_cause <= 1'b0;
      tu3_server_fail_out <= 1'b1;
      tug2_server_fail_out <= 1'b1;
      tu3_trail_fail_action <= 1'b1;
      tug2_trail_fail_action <= 1'b1;
      tug3_data <= 8'h00;
      tug3_stb <= 1'b0;
      tug3_fs <= 1'b0;
      tug3_mfs <= 1'b0;
    end else begin
      label_mismatch_cause <= lbl_act && label_mismatch_defect
                              && !trail_fail_in;
      multiframe_loss_cause <= lbl_act && multiframe_loss_defect && !trail_fail_in
                               && !label_mismatch_defect;
      tu3_server_fail_out <= tu3_server_fail_action;
      tug2_server_fail_out <= tug2_server_fail_action;
      tu3_trail_fail_action <= tu3_server_fail_action;
      tug2_trail_fail_action <= tug2_server_fail_action;
      tug3_stb <= byte_stb;
      tug3_fs <= byte_stb && fs_now;
      tug3_mfs <= is_label && in_mf && (mf_code == `TMAS_MF_FIRST);
      if (byte_stb) begin
        tug3_data <= d3;
      end
    end
  end

  // vc-3 sink fed with this timeslot; lower-order sinks are not built here
  assign pif.byte_stb = byte_stb;
  assign pif.data = d3;
  assign pif.frame_start = fs_now;
  assign pif.is_ptr1 = my_slot && (slot_idx == `TMAS_PTR1_IDX);
  assign pif.is_ptr2 = my_slot && (slot_idx == `TMAS_PTR2_IDX);
  assign pif.is_pay = my_slot && (slot_idx > `TMAS_PTR2_IDX);
  assign pif.tsf = tu3_trail_fail_action;
  assign pif.activate = ctrl[`TMAS_CTL_VC3_ACT];
  assign pif.ais_opt = ctrl[`TMAS_CTL_AIS_REP];

  tmas_ptr_sink u_vc3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .p(pif.sink)
  );

  assign adapted_data_out = pif.out_data;
  assign vc3_stb = pif.out_stb;
  assign vc3_fs = pif.out_fs;
  assign vc3_server_fail = pif.ssf;

  // axi4-lite slave: address and data may arrive in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_got || aw_hs;
  wire have_w = w_got || w_hs;
  wire do_wr = have_aw && have_w;
  wire [7:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_got ? w_strb : s_axi_wstrb;
  wire wr_ctrl = wr_addr == `TMAS_CTRL_ADDR;
  wire wr_known = wr_ctrl || (wr_addr == `TMAS_STAT_ADDR);
  wire next_aw_got = have_aw && !do_wr;
  wire next_w_got = have_w && !do_wr;
  wire next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire rd_ctrl = s_axi_araddr == `TMAS_CTRL_ADDR;
  wire rd_stat = s_axi_araddr == `TMAS_STAT_ADDR;
  wire [31:0] stat_word = {20'h0, label_accepted, in_mf, pif.lop_def, pif.ais_def,
                           multiframe_loss_defect, label_mismatch_defect,
                           pif.ais_cause, pif.lop_cause, multiframe_loss_cause,
                           label_mismatch_cause};
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl} : (rd_stat ? stat_word : 32'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMAS_RESP_OK;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_wr) begin
        s_axi_bresp <= wr_known ? `TMAS_RESP_OK : `TMAS_RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `TMAS_CTRL_RST;
    end else if (do_wr && wr_ctrl && wr_strb[0]) begin
      ctrl <= wr_data[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TMAS_RESP_OK;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_ctrl || rd_stat) ? `TMAS_RESP_OK : `TMAS_RESP_ERR;
      end
    end
  end
endmodule : tmas_sink
`default_nettype wire
